// [pkg/protect_cfg_pkg.sv]
`default_nettype none
package protect_cfg_pkg;
  // ==========================================================================
  // Register location and bit layout
  localparam logic [15:0] CFG_REG_ADDR  = 16'hFFFF;
  localparam int          BIT_HWPE      = 7;
  localparam int          BIT_WD_HI     = 6;
  localparam int          BIT_WD_LO     = 5;
  localparam int          BIT_BP_1      = 4;
  localparam int          BIT_BP_0      = 3;
  localparam int          BIT_RWL       = 2;
  localparam int          BIT_WEL       = 1;
  localparam int          BIT_BP_2      = 0;
  localparam logic [7:0]  CMD_WEL_SET   = 8'h02;
  localparam logic [7:0]  CMD_WEL_CLR   = 8'h00;
  localparam logic [7:0]  CMD_RWL_SET   = 8'h06;
  localparam logic [7:0]  TRIP_DATA     = 8'h00;
  // Factory image of the stored fields when no image is supplied
  localparam logic [7:0]  NV_FACTORY    = 8'h00;

  // ==========================================================================
  // Array geometry and protected ranges
  localparam int          ARR_AW        = 14;
  localparam int          PAGE_AW       = 6;
  localparam logic [13:0] RANGE_Q4_LO   = 14'h3000;
  localparam logic [13:0] RANGE_HALF_LO = 14'h2000;
  localparam logic [13:0] RANGE_ALL_LO  = 14'h0000;
  localparam logic [13:0] RANGE_P1_HI   = 14'h003F;
  localparam logic [13:0] RANGE_P2_HI   = 14'h007F;
  localparam logic [13:0] RANGE_P4_HI   = 14'h00FF;
  localparam logic [13:0] RANGE_P8_HI   = 14'h01FF;

  // ==========================================================================
  // Timing
  localparam int          CLK_HZ        = 50_000_000;
  localparam int          NV_CYCLE_MS   = 10;
  localparam int          NV_CYCLES     = NV_CYCLE_MS * (CLK_HZ / 1000);
  localparam logic [10:0] WD_T00_MS     = 11'd1400;
  localparam logic [10:0] WD_T01_MS     = 11'd600;
  localparam logic [10:0] WD_T10_MS     = 11'd200;
  localparam logic [10:0] WD_OFF_MS     = 11'd0;

  // Pin vector positions
  localparam int          PIN_WP        = 0;
  localparam int          PIN_HV        = 1;
endpackage
`default_nettype wire

// [rtl/supervisor_ctrl_reg_protect.sv]
// Functional notes
// - Config register at FFFF, one data byte
// - NACK every register byte after the first
// - Stop after byte starts stored-field cycle
// - Register readable when idle, one byte, then reset
// - Bit layout: protect, period, block, latches
// - Register update needs write latch set
// - Write enable latch clear at power-up
// - Enable latch clear: ignore writes, NACK data
// - 02 sets enable latch, 00 clears it
// - Enable-only update: no cycle, ready immediately
// - Codes 001-011 protect quarter, half, all
// - Codes 1xx protect first 1,2,4,8 pages
// - Discard writes inside protected range
// - Period codes: 1.4s, 600ms, 200ms, off
// - Hardware protect = pin AND enable bit
// - Hardware protect locks stored fields only
// - Enable bit cannot clear while pin high
// - Stored fields survive power removal
// - Sequence 02, 06, value; bit2 set keeps fields
// - Store cycle up to 10ms clears latch
// - Write latch clears only on store/reset/protect
`default_nettype none
module supervisor_ctrl_reg_protect
  import protect_cfg_pkg::*;
#(
  parameter int NV_WAIT = NV_CYCLES
) (
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  input  wire logic [7:0]  i_nv_image,
  input  wire logic        i_wp_pin,
  input  wire logic        i_hv_detect,
  input  wire logic        i_wr_begin,
  input  wire logic [15:0] i_wr_addr,
  input  wire logic        i_data_valid,
  input  wire logic [7:0]  i_data,
  input  wire logic        i_stop,
  input  wire logic        i_rd_req,
  input  wire logic [15:0] i_rd_addr,
  output logic             o_ack,
  output logic             o_array_byte_ok,
  output logic [13:0]      o_array_addr,
  output logic             o_array_commit,
  output logic [7:0]       o_rd_data,
  output logic             o_rd_valid,
  output logic             o_nv_store,
  output logic [7:0]       o_nv_data,
  output logic             o_busy,
  output logic             o_trip_start,
  output logic             o_trip_done,
  output logic             o_hw_protect,
  output logic [1:0]       o_wd_period_sel,
  output logic [10:0]      o_wd_timeout_ms
);

  // ==========================================================================
  // State
  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_REG   = 6'b000010,
    ST_REGX  = 6'b000100,
    ST_ARRAY = 6'b001000,
    ST_NV    = 6'b010000,
    ST_TRIP  = 6'b100000
  } state_e;

  typedef struct packed {
    state_e      st;
    logic [1:0]  sy1;
    logic [1:0]  sy2;
    logic [1:0]  sy3;
    logic [1:0]  pin;
    logic        hwpe;
    logic [1:0]  wd;
    logic [2:0]  bp;
    logic        rwl;
    logic        write_enable_latch;
    logic [13:0] addr;
    logic        got_byte;
    logic        pend_wel;
    logic        pend_wel_val;
    logic        pend_rwl;
    logic        pend_nv;
    logic [7:0]  pend_nv_val;
    logic        pend_trip;
    logic        any_arr;
    logic [19:0] cnt;
    logic        ack;
    logic        arr_ok;
    logic [13:0] arr_addr;
    logic        arr_commit;
    logic [7:0]  rd_data;
    logic        rd_valid;
    logic        nv_store;
    logic [7:0]  nv_data;
    logic        busy;
    logic        trip_start;
    logic        trip_done;
    logic        hw_prot;
    logic [10:0] wd_ms;
  } state_s;

  state_s state_ff;
  state_s nxt_state;

  // Counter load truncated on purpose to the counter width
  localparam logic [19:0] NV_LOAD = 20'(NV_WAIT - 1);

  // ==========================================================================
  // Helpers
  // Protected-range decode, code taken as {bit0, bit4, bit3}
  function automatic logic in_protected(input logic [2:0] code, input logic [13:0] a);
    logic r;
    r = 1'b0;
    case (code)
      3'b000:  r = 1'b0;
      3'b001:  r = (a >= RANGE_Q4_LO);
      3'b010:  r = (a >= RANGE_HALF_LO);
      3'b011:  r = (a >= RANGE_ALL_LO);
      3'b100:  r = (a <= RANGE_P1_HI);
      3'b101:  r = (a <= RANGE_P2_HI);
      3'b110:  r = (a <= RANGE_P4_HI);
      3'b111:  r = (a <= RANGE_P8_HI);
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  function automatic logic [10:0] wd_time(input logic [1:0] sel);
    logic [10:0] t;
    t = WD_OFF_MS;
    case (sel)
      2'b00:   t = WD_T00_MS;
      2'b01:   t = WD_T01_MS;
      2'b10:   t = WD_T10_MS;
      default: t = WD_OFF_MS;
    endcase
    return t;
  endfunction

  // Register image; latches are live, fields are the stored copy
  function automatic logic [7:0] cfg_byte(input state_s s);
    logic [7:0] b;
    b            = 8'h00;
    b[BIT_HWPE]  = s.hwpe;
    b[BIT_WD_HI] = s.wd[1];
    b[BIT_WD_LO] = s.wd[0];
    b[BIT_BP_1]  = s.bp[1];
    b[BIT_BP_0]  = s.bp[0];
    b[BIT_RWL]   = s.rwl;
    b[BIT_WEL]   = s.write_enable_latch;
    b[BIT_BP_2]  = s.bp[2];
    return b;
  endfunction

  // ==========================================================================
  // Next-state logic
  // Pins pass three flops; the filtered level moves only when the
  // second and third agree, so a single glitchy sample is never seen.
  always_comb begin
    logic       hwp;
    logic [7:0] d;
    hwp       = 1'b0;
    d         = i_data;
    nxt_state = state_ff;
    nxt_state.sy1 = {i_hv_detect, i_wp_pin};
    nxt_state.sy2 = state_ff.sy1;
    nxt_state.sy3 = state_ff.sy2;
    if (state_ff.sy2 == state_ff.sy3) begin
      nxt_state.pin = state_ff.sy3;
    end
    hwp = state_ff.pin[PIN_WP] & state_ff.hwpe;

    // One-cycle strobes default low
    nxt_state.arr_ok     = 1'b0;
    nxt_state.arr_commit = 1'b0;
    nxt_state.rd_valid   = 1'b0;
    nxt_state.nv_store   = 1'b0;
    nxt_state.trip_start = 1'b0;
    nxt_state.trip_done  = 1'b0;

    case (state_ff.st)
      ST_IDLE: begin
        if (i_wr_begin) begin
          nxt_state.addr      = i_wr_addr[ARR_AW-1:0];
          nxt_state.got_byte  = 1'b0;
          nxt_state.pend_wel  = 1'b0;
          nxt_state.pend_rwl  = 1'b0;
          nxt_state.pend_nv   = 1'b0;
          nxt_state.pend_trip = 1'b0;
          nxt_state.any_arr   = 1'b0;
          nxt_state.ack       = 1'b0;
          nxt_state.st = (i_wr_addr == CFG_REG_ADDR) ? ST_REG : ST_ARRAY;
        end else if (i_rd_req && i_rd_addr == CFG_REG_ADDR) begin
          nxt_state.rd_data  = cfg_byte(state_ff);
          nxt_state.rd_valid = 1'b1;
        end
      end

      ST_REG: begin
        if (i_data_valid && !state_ff.got_byte) begin
          nxt_state.got_byte = 1'b1;
          nxt_state.ack      = 1'b0;
          // Store request first, so 02 with write latch set means all-zero fields
          if (state_ff.write_enable_latch && state_ff.rwl && d[BIT_RWL] == 1'b0 && d[BIT_WEL]) begin
            if (hwp) begin
              nxt_state.rwl = 1'b0;
            end else begin
              nxt_state.pend_nv     = 1'b1;
              nxt_state.pend_nv_val = d;
              nxt_state.ack         = 1'b1;
            end
          end else if (d == CMD_WEL_SET || d == CMD_WEL_CLR) begin
            nxt_state.pend_wel     = 1'b1;
            nxt_state.pend_wel_val = d[BIT_WEL];
            nxt_state.ack          = 1'b1;
          end else if (!state_ff.write_enable_latch) begin
            nxt_state.ack = 1'b0;
          end else if (d[BIT_RWL] && (d == CMD_RWL_SET || state_ff.rwl)) begin
            nxt_state.pend_rwl = 1'b1;
            nxt_state.ack      = 1'b1;
          end else begin
            nxt_state.ack = 1'b0;
          end
        end else if (i_data_valid) begin
          // Extra byte aborts the whole register write
          nxt_state.ack      = 1'b0;
          nxt_state.pend_wel = 1'b0;
          nxt_state.pend_rwl = 1'b0;
          nxt_state.pend_nv  = 1'b0;
          nxt_state.st       = ST_REGX;
        end else if (i_stop) begin
          if (state_ff.pend_wel) begin
            nxt_state.write_enable_latch = state_ff.pend_wel_val;
          end
          if (state_ff.pend_rwl) begin
            nxt_state.rwl = 1'b1;
            nxt_state.write_enable_latch = 1'b1;
          end
          if (state_ff.pend_nv) begin
            nxt_state.nv_store = 1'b1;
            nxt_state.nv_data  = state_ff.pend_nv_val;
            nxt_state.cnt      = NV_LOAD;
            nxt_state.busy     = 1'b1;
            nxt_state.st       = ST_NV;
          end else begin
            nxt_state.st = ST_IDLE;
          end
        end
      end

      ST_REGX: begin
        if (i_data_valid) begin
          nxt_state.ack = 1'b0;
        end
        if (i_stop) begin
          nxt_state.st = ST_IDLE;
        end
      end

      ST_ARRAY: begin
        if (i_data_valid) begin
          nxt_state.got_byte = 1'b1;
          // Page counter rolls within the page
          nxt_state.addr[PAGE_AW-1:0] = state_ff.addr[PAGE_AW-1:0] + 6'h01;
          if (!state_ff.write_enable_latch) begin
            nxt_state.ack = 1'b0;
          end else if (state_ff.pin[PIN_HV]) begin
            // Trip programming byte, never an array write
            nxt_state.ack       = (d == TRIP_DATA);
            nxt_state.pend_trip = (d == TRIP_DATA) && !state_ff.got_byte;
          end else if (in_protected(state_ff.bp, state_ff.addr)) begin
            nxt_state.ack = 1'b0;
            nxt_state.rwl = 1'b0;
          end else begin
            nxt_state.ack      = 1'b1;
            nxt_state.arr_ok   = 1'b1;
            nxt_state.arr_addr = state_ff.addr;
            nxt_state.any_arr  = 1'b1;
          end
        end else if (i_stop) begin
          nxt_state.arr_commit = state_ff.any_arr;
          if (state_ff.pend_trip && state_ff.pin[PIN_HV]) begin
            nxt_state.trip_start = 1'b1;
            nxt_state.busy       = 1'b1;
            nxt_state.st         = ST_TRIP;
          end else begin
            nxt_state.st = ST_IDLE;
          end
        end
      end

      ST_NV: begin
        // Inputs are ignored for the whole store cycle
        if (state_ff.cnt == 20'h00000) begin
          nxt_state.hwpe = state_ff.nv_data[BIT_HWPE];
          nxt_state.wd   = {state_ff.nv_data[BIT_WD_HI], state_ff.nv_data[BIT_WD_LO]};
          nxt_state.bp   = {state_ff.nv_data[BIT_BP_2], state_ff.nv_data[BIT_BP_1],
                            state_ff.nv_data[BIT_BP_0]};
          nxt_state.rwl  = 1'b0;
          nxt_state.busy = 1'b0;
          nxt_state.st   = ST_IDLE;
        end else begin
          nxt_state.cnt = state_ff.cnt - 20'h00001;
        end
      end

      ST_TRIP: begin
        // Programming ends when the high level leaves the protect pin
        if (!state_ff.pin[PIN_HV]) begin
          nxt_state.trip_done = 1'b1;
          nxt_state.busy      = 1'b0;
          nxt_state.st        = ST_IDLE;
        end
      end

      default: begin
        nxt_state.st = ST_IDLE;
      end
    endcase

    nxt_state.hw_prot = hwp;
    nxt_state.wd_ms   = wd_time(state_ff.wd);

    // Power-up: latches clear, stored fields reload from the image
    if (i_rst) begin
      nxt_state         = '0;
      nxt_state.st      = ST_IDLE;
      nxt_state.write_enable_latch     = 1'b0;
      nxt_state.rwl     = 1'b0;
      nxt_state.hwpe    = i_nv_image[BIT_HWPE];
      nxt_state.wd      = {i_nv_image[BIT_WD_HI], i_nv_image[BIT_WD_LO]};
      nxt_state.bp      = {i_nv_image[BIT_BP_2], i_nv_image[BIT_BP_1],
                           i_nv_image[BIT_BP_0]};
      nxt_state.wd_ms   = WD_T00_MS;
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge i_clock) begin
    state_ff <= nxt_state;
  end

  // ==========================================================================
  // Outputs, all straight from the state register
  assign o_ack           = state_ff.ack;
  assign o_array_byte_ok = state_ff.arr_ok;
  assign o_array_addr    = state_ff.arr_addr;
  assign o_array_commit  = state_ff.arr_commit;
  assign o_rd_data       = state_ff.rd_data;
  assign o_rd_valid      = state_ff.rd_valid;
  assign o_nv_store      = state_ff.nv_store;
  assign o_nv_data       = state_ff.nv_data;
  assign o_busy          = state_ff.busy;
  assign o_trip_start    = state_ff.trip_start;
  assign o_trip_done     = state_ff.trip_done;
  assign o_hw_protect    = state_ff.hw_prot;
  assign o_wd_period_sel = state_ff.wd;
  assign o_wd_timeout_ms = state_ff.wd_ms;

endmodule
`default_nettype wire

// [test/protect_properties.sv]
`default_nettype none
module protect_properties
  import protect_cfg_pkg::*;
#(
  parameter int NV_WAIT = NV_CYCLES
) (
  input wire logic        i_clock,
  input wire logic        i_rst,
  input wire logic        i_wp_pin,
  input wire logic        i_data_valid,
  input wire logic        i_stop,
  input wire logic        i_rd_req,
  input wire logic [15:0] i_rd_addr,
  input wire logic        o_ack,
  input wire logic        o_array_byte_ok,
  input wire logic        o_rd_valid,
  input wire logic        o_nv_store,
  input wire logic [7:0]  o_nv_data,
  input wire logic        o_busy,
  input wire logic        o_trip_done,
  input wire logic        o_hw_protect,
  input wire logic [1:0]  o_wd_period_sel,
  input wire logic [10:0] o_wd_timeout_ms
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // ==========================================================================
  // Store cycle length; a counter because the real wait is far past any range
  int store_cnt_ff;
  always_ff @(posedge i_clock) begin
    if (i_rst || !o_busy) store_cnt_ff <= 0;
    else if (o_nv_store || store_cnt_ff != 0) store_cnt_ff <= store_cnt_ff + 1;
  end
  // ==========================================================================
  // Relations at the ports
  a_store_bounded: assert property (store_cnt_ff <= NV_WAIT + 4)
    else $error("store cycle too long");
  a_store_on_stop: assert property (o_nv_store |-> $past(i_stop) && o_busy)
    else $error("store without stop");
  a_store_latch_bits: assert property (o_nv_store |->
    o_nv_data[2:1] == 2'b01 && !o_hw_protect)
    else $error("store with wrong latch bits or under protect");
  a_ack_from_byte: assert property ($rose(o_ack) |-> $past(i_data_valid))
    else $error("ack without data byte");
  a_array_ok_acked: assert property (o_array_byte_ok |-> o_ack && $past(i_data_valid))
    else $error("array byte taken without ack");
  a_read_one_byte: assert property (o_rd_valid |-> $past(i_rd_req)
    && $past(i_rd_addr) == CFG_REG_ADDR ##1 !o_rd_valid) else $error("bad register read");
  a_busy_no_answer: assert property (o_busy && $past(o_busy) |->
    !o_rd_valid && !o_array_byte_ok)
    else $error("answer while busy");
  a_hw_pin_low: assert property (!i_wp_pin [*8] |=> !o_hw_protect)
    else $error("hardware protect with pin low");
  a_wd_period_map: assert property ($stable(o_wd_period_sel) && !$past(i_rst) |->
    o_wd_timeout_ms == (o_wd_period_sel[1] ? (o_wd_period_sel[0] ? 11'h000 : 11'h0C8)
    : (o_wd_period_sel[0] ? 11'h258 : 11'h578))) else $error("watchdog period mismatch");
  a_trip_done_busy: assert property (o_trip_done |-> $past(o_busy))
    else $error("trip done without programming");
endmodule
bind supervisor_ctrl_reg_protect protect_properties #(.NV_WAIT(NV_WAIT)) protect_properties_i (
  .i_clock, .i_rst, .i_wp_pin, .i_data_valid, .i_stop, .i_rd_req, .i_rd_addr, .o_ack,
  .o_array_byte_ok, .o_rd_valid, .o_nv_store, .o_nv_data, .o_busy, .o_trip_done,
  .o_hw_protect, .o_wd_period_sel, .o_wd_timeout_ms);
`default_nettype wire

// [test/serial_master_model.sv]
`default_nettype none
module serial_master_model (
  input  wire logic        i_clock,
  input  wire logic        i_ack,
  input  wire logic        i_rd_valid,
  input  wire logic [7:0]  i_rd_data,
  output var  logic        o_wr_begin,
  output var  logic [15:0] o_wr_addr,
  output var  logic        o_data_valid,
  output var  logic [7:0]  o_data,
  output var  logic        o_stop,
  output var  logic        o_rd_req,
  output var  logic [15:0] o_rd_addr
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {o_wr_begin, o_data_valid, o_stop, o_rd_req} = 4'h0;
    {o_wr_addr, o_data, o_rd_addr} = 40'h0;
  end
  // ==========================================================================
  // Write: begin, n bytes, stop; idle lines show inverted data so nothing stale passes
  task automatic write_op(input logic [15:0] a, input logic [7:0] d0, input logic [7:0] d1,
                          input int n, output logic ack0, output logic ack1);
    ack1 = 1'b0;
    @(negedge i_clock) {o_wr_begin, o_wr_addr} = {1'b1, a};
    @(negedge i_clock) {o_wr_begin, o_wr_addr} = {1'b0, ~a};
    for (int k = 0; k < n; k++) begin
      @(negedge i_clock) {o_data_valid, o_data} = {1'b1, (k == 0) ? d0 : d1};
      @(negedge i_clock) {o_data_valid, o_data} = {1'b0, ~o_data};
      @(negedge i_clock);
      if (k == 0) ack0 = i_ack;
      else ack1 = i_ack;
    end
    // Stop only once the last byte has been answered
    @(negedge i_clock) o_stop = 1'b1;
    @(negedge i_clock) o_stop = 1'b0;
  endtask
  // Random read of one byte; the answer is a one-cycle pulse, so poll a few cycles
  task automatic read_op(input logic [15:0] a, output logic v, output logic [7:0] d);
    {v, d} = 9'h0;
    @(negedge i_clock) {o_rd_req, o_rd_addr} = {1'b1, a};
    @(negedge i_clock) {o_rd_req, o_rd_addr} = {1'b0, ~a};
    repeat (3) begin
      if (i_rd_valid === 1'b1 && v === 1'b0) {v, d} = {1'b1, i_rd_data};
      @(negedge i_clock);
    end
  endtask
endmodule
`default_nettype wire

// [test/supervisor_ctrl_reg_protect_bench.sv]
`default_nettype none
module supervisor_ctrl_reg_protect_bench
  import protect_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_clock = 1'b0, i_rst = 1'b1, i_wp_pin = 1'b0, i_hv_detect = 1'b0;
  logic [7:0]  nv_img = NV_FACTORY;
  logic        wr_begin, data_valid, stop_p, rd_req, a0, a1, v;
  logic        ack, byte_ok, rd_valid, nv_store, busy, trip_done, hw_prot;
  logic        commit, trip_start;
  logic [13:0] arr_addr;
  int          n_ok = 0, n_commit = 0, n_trip = 0;
  logic [15:0] wr_addr, rd_addr;
  logic [7:0]  data_b, rd_data, nv_data, d;
  logic [1:0]  wd_sel;
  logic [10:0] wd_ms;
  int          err_total = 0, checks_done = 0;
  logic [7:0]  vals [3] = '{8'h2A, 8'h52, 8'h7B};
  logic [1:0]  sels [3] = '{2'h1, 2'h2, 2'h3};
  logic [15:0] ms [3] = '{16'h0258, 16'h00C8, 16'h0000};
  logic [15:0] ok_a [3] = '{16'h2FFF, 16'h1FFF, 16'h0200};
  logic [15:0] bad_a [3] = '{16'h3000, 16'h2000, 16'h01FF};
  always #10 i_clock = ~i_clock;
  // Stored-field memory outside the block keeps what each store cycle hands over;
  // pulses are counted at the falling edge, half a cycle after launch, so none is missed
  always @(negedge i_clock) begin
    if (nv_store === 1'b1) nv_img <= nv_data;
    if (byte_ok === 1'b1) n_ok++;
    if (commit === 1'b1) n_commit++;
    if (trip_start === 1'b1) n_trip++;
  end
  supervisor_ctrl_reg_protect #(.NV_WAIT(8)) supervisor_ctrl_reg_protect_i (
    .i_clock(i_clock), .i_rst(i_rst), .i_nv_image(nv_img), .i_wp_pin(i_wp_pin),
    .i_hv_detect(i_hv_detect), .i_wr_begin(wr_begin), .i_wr_addr(wr_addr),
    .i_data_valid(data_valid), .i_data(data_b), .i_stop(stop_p), .i_rd_req(rd_req),
    .i_rd_addr(rd_addr), .o_ack(ack), .o_array_byte_ok(byte_ok), .o_array_addr(arr_addr),
    .o_array_commit(commit), .o_rd_data(rd_data), .o_rd_valid(rd_valid),
    .o_nv_store(nv_store), .o_nv_data(nv_data), .o_busy(busy), .o_trip_start(trip_start),
    .o_trip_done(trip_done),
    .o_hw_protect(hw_prot), .o_wd_period_sel(wd_sel), .o_wd_timeout_ms(wd_ms));
  serial_master_model serial_master_model_i (
    .i_clock(i_clock), .i_ack(ack), .i_rd_valid(rd_valid), .i_rd_data(rd_data),
    .o_wr_begin(wr_begin), .o_wr_addr(wr_addr), .o_data_valid(data_valid), .o_data(data_b),
    .o_stop(stop_p), .o_rd_req(rd_req), .o_rd_addr(rd_addr));
  // ==========================================================================
  // Access and comparison tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Single-byte write, then let any store cycle run out so the next one is not refused
  task automatic wr(input logic [15:0] a, input logic [7:0] dat, input logic ex);
    serial_master_model_i.write_op(a, dat, 8'h00, 1, a0, a1);
    check(16'(a0), 16'(ex));
    for (int k = 0; k < 40 && busy !== 1'b0; k++) @(negedge i_clock);
  endtask
  task automatic rd(input logic [7:0] ex);
    serial_master_model_i.read_op(CFG_REG_ADDR, v, d);
    check(16'(v), 16'h0001);
    check(16'(d), 16'(ex));
  endtask
  task automatic cfg(input logic [7:0] val, input logic ex);
    wr(CFG_REG_ADDR, CMD_WEL_SET, 1'b1);
    wr(CFG_REG_ADDR, CMD_RWL_SET, 1'b1);
    wr(CFG_REG_ADDR, val, ex);
    check(16'(busy), 16'h0000);
  endtask
  task automatic do_reset();
    @(negedge i_clock) i_rst = 1'b1;
    repeat (4) @(negedge i_clock);
    i_rst = 1'b0;
  endtask
  task automatic end_sim();
    $display("checks_done=%0d err_total=%0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    do_reset();
    rd(8'h00);
    check(16'(wd_ms), 16'h0578);
    wr(16'h0100, 8'h55, 1'b0);
    wr(CFG_REG_ADDR, CMD_WEL_SET, 1'b1);
    rd(8'h02);
    wr(CFG_REG_ADDR, 8'h2A, 1'b0);
    rd(8'h02);
    wr(CFG_REG_ADDR, CMD_WEL_CLR, 1'b1);
    rd(8'h00);
    cfg(8'h2E, 1'b1);
    rd(8'h06);
    serial_master_model_i.write_op(CFG_REG_ADDR, 8'h2A, 8'h2A, 2, a0, a1);
    check(16'(a1), 16'h0000);
    check(16'(busy), 16'h0000);
    // Quarter, half and eight-page codes, probed on both sides of each boundary
    for (int t = 0; t < 3; t++) begin
      cfg(vals[t], 1'b1);
      rd(vals[t]);
      check(16'(wd_sel), 16'(sels[t]));
      check(16'(wd_ms), ms[t]);
      wr(ok_a[t], 8'h11, 1'b1);
      check(16'(arr_addr), ok_a[t]);
      wr(CFG_REG_ADDR, CMD_RWL_SET, 1'b1);
      rd(vals[t] | 8'h04);
      wr(bad_a[t], 8'h11, 1'b0);
      rd(vals[t]);
    end
    check(16'(n_ok), 16'h0003);
    check(16'(n_commit), 16'h0003);
    do_reset();
    rd(8'h79);
    cfg(8'h82, 1'b1);
    @(negedge i_clock) i_wp_pin = 1'b1;
    repeat (10) @(negedge i_clock);
    check(16'(hw_prot), 16'h0001);
    cfg(8'h02, 1'b0);
    rd(8'h82);
    wr(16'h0010, 8'hAA, 1'b1);
    @(negedge i_clock) i_wp_pin = 1'b0;
    repeat (10) @(negedge i_clock);
    check(16'(hw_prot), 16'h0000);
    // Both passes run the same trip write and end it by dropping the high level
    for (int t = 0; t < 2; t++) begin
      @(negedge i_clock) {i_wp_pin, i_hv_detect} = 2'b11;
      repeat (10) @(negedge i_clock);
      serial_master_model_i.write_op(16'h0000, TRIP_DATA, 8'h00, 1, a0, a1);
      check(16'(a0), 16'h0001);
      check(16'(busy), 16'h0001);
      {i_wp_pin, i_hv_detect} = 2'b00;
      for (int k = 0; k < 20 && trip_done !== 1'b1; k++) @(negedge i_clock);
      check(16'(trip_done), 16'h0001);
    end
    check(16'(n_trip), 16'h0002);
    check(16'(n_ok), 16'h0004);
    check(16'(n_commit), 16'h0004);
    end_sim();
  end
  // Watchdog: the sequence needs a few thousand cycles at most
  initial begin
    #400000;
    err_total++;
    end_sim();
  end
endmodule
`default_nettype wire
